// *** design/lfsr_regs.sv ***
// led fault status register bank with serial access
`default_nettype none
module lfsr_regs
    import lfsr_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_serial_data_in,       // pin, async
    input  wire logic              i_serial_frame,         // pin, high during a frame
    input  wire logic              i_det_valid,            // detection result strobe
    input  wire logic [LINE_W-1:0] i_det_line,             // line that was measured
    input  wire logic [CHANS-1:0]  i_open_det_ch,          // open-load per channel
    input  wire logic [CHANS-1:0]  i_short_det_ch,         // short per channel
    output var  logic              o_serial_data_out,
    output var  logic [4:0]        o_decouple_enh_applied, // 0 off, else level 1..16
    output var  logic [LINE_W-1:0] o_open_load_line_sel,
    output var  logic [LINE_W-1:0] o_short_line_sel
);
    // ****************************************
    // reset release and pin sync
    // ****************************************
    logic             rst_meta_q;           // reset release stage one
    logic             rst_n_q;              // released reset used everywhere
    logic [1:0]       pins_s;               // synchronised frame, data
    logic             frame_s;
    logic             sdi_s;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    lfsr_sync #(.W(2)) u_pin_sync (
        .i_clk   (i_clk),
        .i_rst_n (rst_n_q),
        .i_d     ({i_serial_frame, i_serial_data_in}),
        .o_q     (pins_s)
    );
    assign frame_s = pins_s[1];
    assign sdi_s   = pins_s[0];

    // ****************************************
    // register state
    // ****************************************
    logic [3:0]        decouple_enh_level_q;      // level code
    logic              decouple_enh_enable_q;     // enhancement on
    logic [LINE_W-1:0] open_load_line_sel_q;      // line for open channel flags
    logic [LINE_W-1:0] short_line_sel_q;          // line for short channel flags
    logic [LINES-1:0]  open_load_line_warn_vec_q; // per-line open warnings
    logic [LINES-1:0]  short_line_warn_vec_q;     // per-line short warnings
    logic [CHANS-1:0]  open_load_channel_vec_q;   // channels open on selected line
    logic [CHANS-1:0]  short_channel_vec_q;       // channels short on selected line

    // read view of a register; unmapped indices read zero
    function automatic logic [REG_W-1:0] read_word(input logic [IDX_W-1:0] idx);
        logic [REG_W-1:0] w;
        w = '0;
        unique case (idx)
            IDX_TUNE: begin
                w[LVL_MSB:LVL_LSB] = decouple_enh_level_q;  // RULE1
                w[EN_BIT]          = decouple_enh_enable_q; // RULE2
            end
            IDX_OPEN_SEL: w[LINE_W-1:0] = open_load_line_sel_q; // RULE3
            IDX_SHRT_SEL: w[LINE_W-1:0] = short_line_sel_q;     // RULE4
            IDX_OPEN_WRN: w[LINES-1:0]  = open_load_line_warn_vec_q; // RULE5
            IDX_SHRT_WRN: w[LINES-1:0]  = short_line_warn_vec_q;     // RULE6
            IDX_OPEN_CH:  w             = open_load_channel_vec_q;   // RULE7
            IDX_SHRT_CH:  w             = short_channel_vec_q;       // RULE8
            default:      w             = '0;
        endcase
        return w;
    endfunction

    // ****************************************
    // serial receive: rw, index, 48 data bits
    // ****************************************
    logic             frame_q;               // frame level one cycle ago
    logic [CNT_W-1:0] cnt_q;                 // bits received in this frame
    logic [FRAME_BITS-1:0] in_q;             // receive shifter
    logic             commit;                // full write frame just ended
    logic             hdr_done;              // last header bit arriving now
    logic [IDX_W-1:0] hdr_idx;               // index as it completes
    logic [REG_W-1:0] out_q;                 // transmit shifter
    logic [REG_W-1:0] rd_word;               // register view for the index just received

    assign hdr_done = frame_s && (cnt_q == HDR_LAST);
    assign hdr_idx  = {in_q[3:0], sdi_s};
    // a frame longer or shorter than a write frame is dropped
    assign commit   = frame_q && !frame_s && (cnt_q == FRAME_LEN) && in_q[FRAME_BITS-1];

    // a process, not an assign, so a register change shows even while the index is steady
    always_comb begin
        rd_word = read_word(hdr_idx);
    end

    // bit counter saturates so overlong frames never wrap onto a legal length
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_q   <= '0;
            frame_q <= 1'b0;
        end else begin
            frame_q <= frame_s;
            if (!frame_s) begin
                cnt_q <= '0;
            end else if (cnt_q != '1) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // receive shifter, msb first
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            in_q <= '0;
        end else if (frame_s) begin
            in_q <= {in_q[FRAME_BITS-2:0], sdi_s}; // RULE9
        end
    end

    // transmit shifter: a read header loads the word, later bits shift it out
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            out_q <= '0;
        end else if (hdr_done && !in_q[4]) begin
            out_q <= read_word(hdr_idx); // RULE9
        end else if (frame_s) begin
            out_q <= {out_q[REG_W-2:0], 1'b0};
        end
    end

    // serial output pin from a flop
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_serial_data_out <= 1'b0;
        end else begin
            o_serial_data_out <= out_q[REG_W-1]; // RULE9
        end
    end

    // ****************************************
    // writable fields
    // ****************************************
    // writes to read-only or unmapped indices are ignored
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            decouple_enh_level_q  <= LVL_RST;
            decouple_enh_enable_q <= EN_RST;                      // RULE2
            open_load_line_sel_q  <= SEL_RST;
            short_line_sel_q      <= SEL_RST;
        end else if (commit) begin
            unique case (in_q[52:48])
                IDX_TUNE: begin
                    decouple_enh_level_q  <= in_q[LVL_MSB:LVL_LSB]; // RULE1
                    decouple_enh_enable_q <= in_q[EN_BIT];          // RULE2
                end
                IDX_OPEN_SEL: open_load_line_sel_q <= in_q[LINE_W-1:0]; // RULE3
                IDX_SHRT_SEL: short_line_sel_q     <= in_q[LINE_W-1:0]; // RULE4
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // fault capture from the scan engine
    // ****************************************
    // each pass overwrites the line bit, so a cleared fault disappears
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            open_load_line_warn_vec_q <= '0;
            short_line_warn_vec_q     <= '0;
        end else if (i_det_valid) begin
            open_load_line_warn_vec_q[i_det_line] <= |i_open_det_ch;  // RULE5
            short_line_warn_vec_q[i_det_line]     <= |i_short_det_ch; // RULE6
        end
    end

    // channel vectors only take results from the selected line
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            open_load_channel_vec_q <= '0;
            short_channel_vec_q     <= '0;
        end else if (i_det_valid) begin
            if (i_det_line == open_load_line_sel_q) begin
                open_load_channel_vec_q <= i_open_det_ch;  // RULE7 RULE10
            end
            if (i_det_line == short_line_sel_q) begin
                short_channel_vec_q <= i_short_det_ch;     // RULE8 RULE10
            end
        end
    end

    // ****************************************
    // outputs to the analog and scan logic
    // ****************************************
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_decouple_enh_applied <= '0;
            o_open_load_line_sel   <= SEL_RST;
            o_short_line_sel       <= SEL_RST;
        end else begin
            o_decouple_enh_applied <= decouple_enh_enable_q ?
                                      ({1'b0, decouple_enh_level_q} + 5'h01) : 5'h00; // RULE1 RULE2
            o_open_load_line_sel   <= open_load_line_sel_q;
            o_short_line_sel       <= short_line_sel_q;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n_q);

    level_apply_a: assert property (decouple_enh_enable_q |=> // RULE1
        o_decouple_enh_applied == {1'b0, $past(decouple_enh_level_q)} + 5'h01)
        else $error("applied level is not code plus one");
    enh_off_a: assert property (!decouple_enh_enable_q |=> o_decouple_enh_applied == 5'h00) // RULE2
        else $error("enhancement applied while disabled");
    open_sel_wr_a: assert property (commit && in_q[52:48] == IDX_OPEN_SEL |=> // RULE3
        open_load_line_sel_q == $past(in_q[4:0]))
        else $error("open line select not written");
    short_sel_wr_a: assert property (commit && in_q[52:48] == IDX_SHRT_SEL |=> // RULE4
        short_line_sel_q == $past(in_q[4:0]))
        else $error("short line select not written");
    open_warn_a: assert property (i_det_valid |=> // RULE5
        open_load_line_warn_vec_q[$past(i_det_line)] == $past(|i_open_det_ch))
        else $error("open line warning wrong");
    short_warn_a: assert property (i_det_valid |=> // RULE6
        short_line_warn_vec_q[$past(i_det_line)] == $past(|i_short_det_ch))
        else $error("short line warning wrong");
    open_ch_a: assert property (i_det_valid && i_det_line == open_load_line_sel_q |=> // RULE7
        open_load_channel_vec_q == $past(i_open_det_ch))
        else $error("open channel vector not captured");
    short_ch_a: assert property (i_det_valid && i_det_line == short_line_sel_q |=> // RULE8
        short_channel_vec_q == $past(i_short_det_ch))
        else $error("short channel vector not captured");
    other_line_a: assert property (i_det_valid && i_det_line != open_load_line_sel_q |=> // RULE10
        $stable(open_load_channel_vec_q))
        else $error("open channel vector took another line");
    read_out_a: assert property (hdr_done && !in_q[4] |-> ##2 // RULE9
        o_serial_data_out == $past(rd_word[REG_W-1], 2))
        else $error("read word msb not on serial out");
    sdo_follow_a: assert property (##1 o_serial_data_out == $past(out_q[REG_W-1])) // RULE9
        else $error("serial out not from shifter");

    write_cv: cover property (commit);
    read_cv: cover property (hdr_done && !in_q[4]);
    enh_cv: cover property (decouple_enh_enable_q && decouple_enh_level_q == 4'hF);
    fault_cv: cover property (i_det_valid && |i_open_det_ch && i_det_line == open_load_line_sel_q);
endmodule
`default_nettype wire

// *** design/lfsr_pkg.sv ***
// package of constants for the led fault status register bank
// Notes on behaviour
// RULE1: four-bit enhancement level, code plus one
// RULE2: enhancement applied only while enable set
// RULE3: five-bit open-load line select, rest zero
// RULE4: five-bit short line select, rest zero
// RULE5: open-load line warnings, lines 0-31
// RULE6: short line warnings, lines 0-31
// RULE7: 48-bit open-load channel flag vector
// RULE8: 48-bit short channel flag vector
// RULE9: writes via serial in, reads via out
// RULE10: channel vectors follow selected scan line
`default_nettype none
package lfsr_pkg;
    // ****************************************
    // register geometry
    // ****************************************
    localparam int          REG_W        = 48;    // every register is 48 bits
    localparam int          IDX_W        = 5;     // register index width
    localparam int          LINES        = 32;    // scan lines
    localparam int          LINE_W       = 5;     // scan line code width
    localparam int          CHANS        = 48;    // current channels
    // register indices
    localparam logic [4:0]  IDX_TUNE     = 5'h04; // display_tuning_control
    localparam logic [4:0]  IDX_OPEN_SEL = 5'h0E; // open_load_line_select
    localparam logic [4:0]  IDX_SHRT_SEL = 5'h0F; // short_line_select
    localparam logic [4:0]  IDX_OPEN_WRN = 5'h11; // open_load_line_warnings
    localparam logic [4:0]  IDX_SHRT_WRN = 5'h13; // short_line_warnings
    localparam logic [4:0]  IDX_OPEN_CH  = 5'h14; // open_load_channel_flags
    localparam logic [4:0]  IDX_SHRT_CH  = 5'h15; // short_channel_flags
    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int          LVL_LSB      = 40;    // decouple_enh_level 43:40
    localparam int          LVL_MSB      = 43;
    localparam int          EN_BIT       = 44;    // decouple_enh_enable
    localparam logic [3:0]  LVL_RST      = 4'h8;
    localparam logic        EN_RST       = 1'b0;
    localparam logic [4:0]  SEL_RST      = 5'h00;
    // ****************************************
    // serial frame layout: rw, index, data
    // ****************************************
    localparam int          HDR_BITS     = 6;
    localparam int          FRAME_BITS   = 54;
    localparam int          CNT_W        = 6;
    localparam logic [5:0]  HDR_LAST     = 6'h05;  // count while last header bit arrives
    localparam logic [5:0]  FRAME_LEN    = 6'h36;  // bits in a full write frame
endpackage
`default_nettype wire

// *** design/lfsr_sync.sv ***
// two flip-flop synchroniser for pin inputs
`default_nettype none
module lfsr_sync #(
    parameter int W = 1                 // number of bits
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_d,
    output var  logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;               // first stage, read only by second stage

    // ****************************************
    // two stages, no logic between them
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** verif/lfsr_ctl_model.sv ***
// display controller model driving the serial register link
`default_nettype none
module lfsr_ctl_model (
    input  wire logic i_clk,
    input  wire logic i_sdo,
    output var  logic o_sdi,
    output var  logic o_frame
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0; // high while a frame is on the link
    initial o_sdi = 1'b0;
    initial o_frame = 1'b0;
    // ****************************************
    // link driver
    // ****************************************
    // idle data line toggles so a stale bit never passes for a real one
    always @(negedge i_clk) begin
        if (!busy) begin
            o_sdi <= ~o_sdi;
        end
    end
    // one frame: rw, index msb first, then nd data bits msb first
    task automatic xfer(input logic rw, input logic [4:0] idx, input logic [47:0] wd, input int nd,
                        output logic [47:0] rd);
        logic [53:0] bits;
        bits = {rw, idx, wd};
        rd = '0;
        busy = 1'b1;
        for (int i = 53; i >= 48 - nd; i--) begin
            @(negedge i_clk);
            o_frame <= 1'b1;
            o_sdi <= bits[i];
        end
        // msb stands after the fourth rising edge that follows the last header bit
        if (!rw) begin
            repeat (4) @(posedge i_clk);
            for (int i = 47; i >= 0; i--) begin
                @(negedge i_clk);
                rd[i] = i_sdo;
            end
        end
        @(negedge i_clk);
        o_frame <= 1'b0;
        // gap covers the frame-low spacing and the write settling
        repeat (8) @(posedge i_clk);
        busy = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the led fault status register bank
`default_nettype none
module tb_top
    import lfsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              i_clk       = 1'b0;
    logic              i_nrst      = 1'b0;
    logic              sdi;
    logic              frame;
    logic              sdo;
    logic              det_valid   = 1'b0;
    logic [LINE_W-1:0] det_line    = '0;
    logic [CHANS-1:0]  det_open    = '0;
    logic [CHANS-1:0]  det_short   = '0;
    logic [4:0]        applied;
    logic [4:0]        osel_o;
    logic [4:0]        ssel_o;
    int                err_count   = 0;
    int                checks_done = 0;
    int                seed        = 96315;
    logic [47:0]       rd;
    logic [47:0]       w;
    // shadow copy of what the registers must hold
    logic [3:0]        e_lvl       = 4'h8;
    logic              e_en        = 1'b0;
    logic [4:0]        e_osel      = 5'h00;
    logic [4:0]        e_ssel      = 5'h00;
    logic [31:0]       e_owarn     = '0;
    logic [31:0]       e_swarn     = '0;
    logic [47:0]       e_och       = '0;
    logic [47:0]       e_sch       = '0;
    always #25 i_clk = ~i_clk;
    lfsr_regs DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_serial_data_in(sdi), .i_serial_frame(frame),
        .i_det_valid(det_valid), .i_det_line(det_line), .i_open_det_ch(det_open),
        .i_short_det_ch(det_short), .o_serial_data_out(sdo), .o_decouple_enh_applied(applied),
        .o_open_load_line_sel(osel_o), .o_short_line_sel(ssel_o));
    lfsr_ctl_model ctl (.i_clk(i_clk), .i_sdo(sdo), .o_sdi(sdi), .o_frame(frame));
    // ****************************************
    // expectations and compares
    // ****************************************
    function automatic logic [47:0] e_tune();
        return {3'h0, e_en, e_lvl, 40'h0};
    endfunction
    function automatic logic [4:0] e_app();
        return e_en ? ({1'b0, e_lvl} + 5'h01) : 5'h00;
    endfunction
    task automatic chk48(input string nm, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk5(input string nm, input logic [4:0] exp, input logic [4:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [4:0] idx, input logic [47:0] exp);
        logic [47:0] got;
        ctl.xfer(1'b0, idx, 48'h0, 0, got);
        chk48("register read", exp, got);
    endtask
    task automatic check_all();
        rd_chk(IDX_TUNE, e_tune());
        rd_chk(IDX_OPEN_SEL, {43'h0, e_osel});
        rd_chk(IDX_SHRT_SEL, {43'h0, e_ssel});
        rd_chk(IDX_OPEN_WRN, {16'h0, e_owarn});
        rd_chk(IDX_SHRT_WRN, {16'h0, e_swarn});
        rd_chk(IDX_OPEN_CH, e_och);
        rd_chk(IDX_SHRT_CH, e_sch);
        chk5("open select port", e_osel, osel_o);
        chk5("short select port", e_ssel, ssel_o);
        chk5("applied level", e_app(), applied);
    endtask
    // one scan result pass from the scan engine side
    task automatic detect(input logic [4:0] ln, input logic [47:0] op, input logic [47:0] sh);
        @(negedge i_clk);
        det_valid <= 1'b1;
        det_line <= ln;
        det_open <= op;
        det_short <= sh;
        @(negedge i_clk);
        det_valid <= 1'b0;
        det_open <= {$random(seed), $random(seed)};
        det_short <= {$random(seed), $random(seed)};
        e_owarn[ln] = |op;
        e_swarn[ln] = |sh;
        if (ln == e_osel) e_och = op;
        if (ln == e_ssel) e_sch = sh;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (3) @(negedge i_clk);
        i_nrst = 1'b1;
        repeat (6) @(negedge i_clk);
        check_all();
        rd_chk(5'h00, 48'h0);
        // every level code, enable alternating, random noise elsewhere
        for (int k = 0; k < 16; k++) begin
            w = {$random(seed), $random(seed)};
            w[44:40] = {k[0], k[3:0]};
            e_lvl = k[3:0];
            e_en = k[0];
            ctl.xfer(1'b1, IDX_TUNE, w, 48, rd);
            chk5("applied level", e_app(), applied);
            rd_chk(IDX_TUNE, e_tune());
        end
        // select fields with the corner codes last, upper bits noisy
        for (int k = 0; k < 6; k++) begin
            w = {$random(seed), $random(seed)};
            w[4:0] = (k == 4) ? 5'h00 : ((k == 5) ? 5'h1F : w[4:0]);
            e_osel = w[4:0];
            e_ssel = ~w[4:0];
            ctl.xfer(1'b1, IDX_OPEN_SEL, w, 48, rd);
            ctl.xfer(1'b1, IDX_SHRT_SEL, ~w, 48, rd);
            check_all();
        end
        // scan passes in pairs, the first on the open select line for odd k, else on a random line, the second on the short select line, one idle cycle apart
        for (int k = 0; k < 40; k++) begin
            w = (k % 5 == 0) ? 48'h0 : {$random(seed), $random(seed)};
            detect(k[0] ? e_osel : 5'($random(seed)), w, {$random(seed), $random(seed)});
            detect(e_ssel, ~w, (k % 3 == 0) ? 48'h0 : w);
        end
        detect(5'h1F, 48'h800000000001, 48'h0);
        check_all();
        // refused writes leave everything as it was
        ctl.xfer(1'b1, IDX_OPEN_WRN, 48'hFFFFFFFFFFFF, 48, rd);
        ctl.xfer(1'b1, IDX_SHRT_CH, 48'hFFFFFFFFFFFF, 48, rd);
        ctl.xfer(1'b1, IDX_TUNE, 48'h1F0000000000, 47, rd);
        ctl.xfer(1'b1, 5'h1F, 48'hFFFFFFFFFFFF, 48, rd);
        check_all();
        rd_chk(5'h1F, 48'h0);
        wrap_up();
    end
    // cuts a hang short
    initial begin
        repeat (60000) @(posedge i_clk);
        err_count++;
        $display("[FAIL] run length expected finished seen still running");
        wrap_up();
    end
endmodule
`default_nettype wire
